// ### logic/dpra_arbiter.sv
// two-function pci request arbiter: video and audio dma share one req/gnt pair
// assumes sys_clk is the pci clock, all pins are synchronous to it and active low,
// and the enables come from a configuration register on the same clock
`timescale 1ns/1ps

module dpra_arbiter (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] func_req,
    output logic [1:0] func_gnt,
    output logic pci_req_n,
    input wire logic pci_gnt_n,
    input wire logic pci_frame_n,
    input wire logic pci_irdy_n,
    input wire logic early_req_release_compat_en,
    input wire logic grant_needs_request_en
);

    typedef struct packed {
        logic compat;
        logic gnt_qual;
    } dpra_ctl_s;

    dpra_ctl_s ctl_q;
    dpra_ctl_s ctl_d;
    logic gnt_seen;
    logic frame_act;
    logic bus_idle;
    logic sel_now;
    logic locked;
    logic tenure;
    logic owner;
    logic sel;
    logic req_act;
    logic gnt_eff;

    // ****************************************************************
    // mode enables
    // ****************************************************************
    // a registered copy keeps mode changes on clean clock edges
    always_comb begin
        ctl_d = ctl_q;
        ctl_d.compat = early_req_release_compat_en;
        ctl_d.gnt_qual = grant_needs_request_en;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctl_q <= '{compat: dpra_pkg::EARLY_RELEASE_RST, gnt_qual: dpra_pkg::GNT_QUAL_RST};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // ****************************************************************
    // bus observation
    // ****************************************************************
    // pins share the pci clock, so they are read raw with no synchroniser
    assign gnt_seen = !pci_gnt_n;
    assign frame_act = !pci_frame_n;
    assign bus_idle = pci_frame_n && pci_irdy_n;
    // audio request selects the grant while open
    assign sel_now = func_req[dpra_pkg::FUNC_AUDIO];

    // lock logic only commits early when the compat bit is set
    dpra_lock u_lock (
        .sys_clk(sys_clk),
        .reset(reset),
        .compat_en(ctl_q.compat),
        .gnt_seen(gnt_seen),
        .frame_act(frame_act),
        .bus_idle(bus_idle),
        .sel_now(sel_now),
        .locked(locked),
        .tenure(tenure),
        .owner(owner)
    );

    // ****************************************************************
    // request routing
    // ****************************************************************
    // locked owner holds the select until release
    assign sel = locked ? owner : sel_now;

    // compat locked routes only the owner request
    // owner drops its request with frame, so the pin rises at once
    // the other request cannot hold the pin
    // other request held off until the lock releases at idle
    // otherwise a plain OR
    // limitation: an owner that keeps its request past frame keeps the pin low
    assign req_act = (ctl_q.compat && locked) ? func_req[owner] : (|func_req);
    assign pci_req_n = !req_act;

    // ****************************************************************
    // grant steering
    // ****************************************************************
    // qualify grant with our own request; this kills parking
    // the qualification bit is left to software
    assign gnt_eff = gnt_seen && (!ctl_q.gnt_qual || req_act);
    // index 0 video, index 1 audio
    // one-hot demux of the gated grant
    // no audio request means video, so the bus parks on video
    assign func_gnt[dpra_pkg::FUNC_VIDEO] = gnt_eff && (sel == dpra_pkg::FUNC_VIDEO);
    assign func_gnt[dpra_pkg::FUNC_AUDIO] = gnt_eff && (sel == dpra_pkg::FUNC_AUDIO);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking dpra_cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_tenure_start;
        gnt_seen && frame_act && !locked;
    endsequence

    sequence s_bus_done;
        tenure && bus_idle;
    endsequence

    a_one_grant: assert property (!(func_gnt[0] && func_gnt[1]))
        else $error("both functions granted");
    a_req_or: assert property (!ctl_q.compat |-> (req_act == (|func_req)))
        else $error("normal request is not the or of both");
    a_park_video: assert property (
        (gnt_seen && !ctl_q.gnt_qual && !locked && !func_req[1]) |-> func_gnt[0])
        else $error("grant did not park on video");
    a_audio_first: assert property (
        (gnt_eff && !locked && func_req[1]) |-> (func_gnt[1] && !func_gnt[0]))
        else $error("audio lost to video");
    a_no_preempt: assert property (
        (s_tenure_start ##1 (tenure && !bus_idle)) |->
        (func_gnt[$past(sel)] || !gnt_eff) && !func_gnt[!$past(sel)])
        else $error("owner preempted");
    a_lock_grant: assert property (
        (ctl_q.compat && gnt_seen && !locked) |=> (locked && owner == $past(sel_now)))
        else $error("compat lock not taken on grant");
    a_locked_pass: assert property (
        (ctl_q.compat && locked) |-> (pci_req_n == !func_req[owner]))
        else $error("locked request not passed through");
    a_lock_release: assert property (s_bus_done |=> !locked)
        else $error("lock held past idle bus");
    a_gnt_qual: assert property ((ctl_q.gnt_qual && pci_req_n) |-> (func_gnt == 2'h0))
        else $error("grant forwarded without request");
    a_reset_normal: assert property ($fell(reset) |-> (!ctl_q.compat && !ctl_q.gnt_qual))
        else $error("enables set after reset");

    // ****************************************************************
    // lock and routing checks
    // ****************************************************************
    // compat grant taken while the lock is still open
    sequence s_compat_grant;
        ctl_q.compat && gnt_seen && !locked;
    endsequence

    // frame one cycle after a compat grant must land in tenure,
    // whether the lock went through the granted state or straight in
    a_compat_tenure: assert property ((s_compat_grant ##1 frame_act) |=> tenure)
        else $error("compat grant and frame did not reach tenure");

    // before any grant, compat mode still behaves as a plain or
    a_compat_or: assert property (
        (ctl_q.compat && !locked) |-> (req_act == (|func_req)))
        else $error("compat request is not the or before grant");

    // in compat mode the non-owner must never keep the pin low on its own
    a_other_blocked: assert property (
        (ctl_q.compat && locked && !func_req[owner]) |-> pci_req_n)
        else $error("other request held the pin");

    // during a compat tenure only the owner could pull the pin low again
    a_held_off: assert property (
        (ctl_q.compat && tenure) |-> (pci_req_n || func_req[owner]))
        else $error("request reasserted during tenure");

    // the owner may not change while the lock stands
    a_owner_frozen: assert property (
        (locked && $past(locked)) |-> (owner == $past(owner)))
        else $error("owner changed while locked");

    // a locked owner shuts the other function out of the grant
    a_locked_grant: assert property (locked |-> !func_gnt[!owner])
        else $error("non-owner granted while locked");

    // without the compat bit an idle-frame grant must not lock the choice
    a_open_no_lock: assert property (
        (!ctl_q.compat && !locked && !frame_act) |=> !locked)
        else $error("lock taken without compat bit");

    // no internal grant without the external grant pin
    a_gnt_from_pin: assert property ((|func_gnt) |-> gnt_seen)
        else $error("internal grant without external grant");

    // grant lands on index 0 for video and index 1 for audio
    a_grant_index: assert property (
        gnt_eff |-> (func_gnt == (sel ? 2'h2 : 2'h1)))
        else $error("grant on the wrong index");

    // qualified grant still passes while our request is on the pin
    a_qual_pass: assert property (
        (ctl_q.gnt_qual && gnt_seen && !pci_req_n) |-> (|func_gnt))
        else $error("qualified grant blocked with request asserted");

    // the lock is open at the first edge after reset
    a_reset_open: assert property ($fell(reset) |-> !locked)
        else $error("lock closed after reset");

endmodule : dpra_arbiter

// ### logic/dpra_lock.sv
// decision lock for the two-function bus request arbiter
// assumes bus pins are active-high versions already decoded by the parent
`timescale 1ns/1ps

module dpra_lock (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic compat_en,
    input wire logic gnt_seen,
    input wire logic frame_act,
    input wire logic bus_idle,
    input wire logic sel_now,
    output logic locked,
    output logic tenure,
    output logic owner
);

    typedef struct packed {
        dpra_pkg::dpra_lock_e state;
        logic owner;
    } dpra_lock_s;

    dpra_lock_s st_q;
    dpra_lock_s st_d;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        case (st_q.state)
            dpra_pkg::DPRA_OPEN: begin
                // compat lock on grant, frame picks tenure instead of granted
                if (gnt_seen && compat_en) begin
                    st_d.state = frame_act ? dpra_pkg::DPRA_TENURE : dpra_pkg::DPRA_GRANTED;
                    st_d.owner = sel_now;
                end else if (gnt_seen && frame_act) begin
                    st_d.state = dpra_pkg::DPRA_TENURE;
                    st_d.owner = sel_now;
                end
            end
            dpra_pkg::DPRA_GRANTED: begin
                // grant withdrawn before frame: nothing started, reopen
                if (frame_act) begin
                    st_d.state = dpra_pkg::DPRA_TENURE;
                end else if (!gnt_seen) begin
                    st_d.state = dpra_pkg::DPRA_OPEN;
                end
            end
            dpra_pkg::DPRA_TENURE: begin
                // release once frame and irdy both idle
                if (bus_idle) begin
                    st_d.state = dpra_pkg::DPRA_OPEN;
                end
            end
            default: begin
                st_d.state = dpra_pkg::DPRA_OPEN;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q <= '{state: dpra_pkg::DPRA_OPEN, owner: dpra_pkg::FUNC_VIDEO};
        end else begin
            st_q <= st_d;
        end
    end

    assign locked = (st_q.state != dpra_pkg::DPRA_OPEN);
    assign tenure = (st_q.state == dpra_pkg::DPRA_TENURE);
    assign owner = st_q.owner;

endmodule : dpra_lock

// ### logic/dpra_pkg.sv
// package for the two-function bus request arbiter
// assumes one pci clock domain; all pins and function requests are synchronous to it
package dpra_pkg;

    // ****************************************************************
    // function indices on the internal request and grant vectors
    // ****************************************************************
    localparam int unsigned FUNC_COUNT = 2;
    localparam logic FUNC_VIDEO = 1'h0;
    localparam logic FUNC_AUDIO = 1'h1;

    // ****************************************************************
    // reset values of the compatibility enables
    // ****************************************************************
    localparam logic EARLY_RELEASE_RST = 1'h0;
    localparam logic GNT_QUAL_RST = 1'h0;

    // ****************************************************************
    // decision lock states
    // ****************************************************************
    typedef enum logic [1:0] {
        DPRA_OPEN,
        DPRA_GRANTED,
        DPRA_TENURE
    } dpra_lock_e;

endpackage : dpra_pkg

// ### testbench/dpra_sys_arb.sv
// model of the host bus arbiter facing the request arbiter
// assumes one clock; grants a steady request after a set delay, or parks when told
`timescale 1ns/1ps

module dpra_sys_arb #(
    parameter int DLY = 3
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pci_req_n,
    input wire logic park_en,
    output logic pci_gnt_n
);
    logic [3:0] cnt_q;

    // grant follows request; a slow delay lets a late request join in
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pci_gnt_n <= 1'b1;
            cnt_q <= 4'h0;
        end else if (park_en) begin
            pci_gnt_n <= 1'b0;
        end else if (pci_req_n) begin
            pci_gnt_n <= 1'b1;
            cnt_q <= 4'h0;
        end else if (cnt_q == 4'(DLY)) begin
            pci_gnt_n <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : dpra_sys_arb

// ### testbench/dual_function_pci_request_arbiter_test.sv
// self-checking bench for the two-function request arbiter
// assumes the host model above stands on the far side; the bench plays the initiators
`timescale 1ns/1ps

module dual_function_pci_request_arbiter_test;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] func_req = 2'h0;
    logic [1:0] func_gnt;
    logic pci_req_n, pci_gnt_n, park_en = 1'b1;
    logic pci_frame_n = 1'b1;
    logic pci_irdy_n = 1'b1;
    logic compat_en = 1'b0;
    logic qual_en = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // ****************************************************************
    // clock, parts and shared tasks
    // ****************************************************************
    always #4 sys_clk = ~sys_clk;

    dpra_arbiter u_dpra_arbiter (.sys_clk(sys_clk), .reset(reset), .func_req(func_req),
        .func_gnt(func_gnt), .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n),
        .pci_frame_n(pci_frame_n), .pci_irdy_n(pci_irdy_n),
        .early_req_release_compat_en(compat_en), .grant_needs_request_en(qual_en));
    dpra_sys_arb u_dpra_sys_arb (.sys_clk(sys_clk), .reset(reset), .pci_req_n(pci_req_n),
        .park_en(park_en), .pci_gnt_n(pci_gnt_n));

    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    // bounded wait for one grant bit, sampled mid-cycle, never at the launch edge
    task automatic wait_gnt(input int idx);
        @(negedge sys_clk);
        for (int i = 0; i < 20 && func_gnt[idx] !== 1'b1; i++) @(negedge sys_clk);
    endtask : wait_gnt

    task automatic idle(input int n);
        @(posedge sys_clk);
        func_req <= 2'h0;
        pci_frame_n <= 1'b1;
        pci_irdy_n <= 1'b1;
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_park;
        // the host model parks from the first edge after release, seen at the second negedge
        repeat (2) @(negedge sys_clk);
        chk("req_n idle", 2'(1'b1), 2'(pci_req_n));
        chk("park gnt", 2'h1, func_gnt);
        @(posedge sys_clk);
        park_en <= 1'b0;
        idle(2);
        $display("test reset_park done");
    endtask : t_reset_park

    task automatic t_or;
        for (int r = 1; r < 4; r++) begin
            @(posedge sys_clk);
            func_req <= 2'(r);
            @(negedge sys_clk);
            chk("req_n or", 2'h0, 2'(pci_req_n));
            idle(2);
        end
        $display("test or done");
    endtask : t_or

    task automatic t_audio_first;
        @(posedge sys_clk);
        func_req <= 2'h1;
        @(posedge sys_clk);
        func_req <= 2'h3;
        wait_gnt(1);
        chk("late audio gnt", 2'h2, func_gnt);
        idle(3);
        $display("test audio_first done");
    endtask : t_audio_first

    task automatic t_no_preempt;
        @(posedge sys_clk);
        func_req <= 2'h1;
        wait_gnt(0);
        chk("video gnt", 2'h1, func_gnt);
        @(posedge sys_clk);
        pci_frame_n <= 1'b0;
        pci_irdy_n <= 1'b0;
        @(posedge sys_clk);
        func_req <= 2'h3;
        @(negedge sys_clk);
        chk("no preempt", 2'h1, func_gnt);
        idle(3);
        $display("test no_preempt done");
    endtask : t_no_preempt

    task automatic t_compat;
        @(posedge sys_clk);
        compat_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        func_req <= 2'h3;
        wait_gnt(1);
        chk("compat gnt", 2'h2, func_gnt);
        @(posedge sys_clk);
        pci_frame_n <= 1'b0;
        pci_irdy_n <= 1'b0;
        func_req <= 2'h1;
        @(negedge sys_clk);
        chk("locked req_n", 2'h1, 2'(pci_req_n));
        @(posedge sys_clk);
        pci_frame_n <= 1'b1;
        pci_irdy_n <= 1'b1;
        @(negedge sys_clk);
        chk("held req_n", 2'h1, 2'(pci_req_n));
        @(negedge sys_clk);
        chk("freed req_n", 2'h0, 2'(pci_req_n));
        idle(3);
        compat_en <= 1'b0;
        $display("test compat done");
    endtask : t_compat

    task automatic t_qual;
        @(posedge sys_clk);
        qual_en <= 1'b1;
        park_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("qual no req", 2'h0, func_gnt);
        @(posedge sys_clk);
        func_req <= 2'h1;
        @(negedge sys_clk);
        chk("qual req", 2'h1, func_gnt);
        idle(2);
        $display("test qual done");
    endtask : t_qual

    // ****************************************************************
    // watchdog and main sequence
    // ****************************************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_park();
        t_or();
        t_audio_first();
        t_no_preempt();
        t_compat();
        t_qual();
        finish_test();
    end
endmodule : dual_function_pci_request_arbiter_test
